// [tdp_map.svh]
// Offsets-free constant map: port numbering, timing figures and widths for the port control
`ifndef TDP_MAP_SVH
`define TDP_MAP_SVH
// ==========================================================
// Board arrangement
`define TDP_NUM_PORTS    8
`define TDP_NUM_DSP      6
`define TDP_NUM_DTMF     4
`define TDP_NO_DSP       3'h7
// ==========================================================
// Clock and timing figures
`define TDP_CLK_MHZ      200
`define TDP_WD_TIME_US   1000
`define TDP_WD_CYCLES    (`TDP_WD_TIME_US * `TDP_CLK_MHZ)
`define TDP_FLT_TIME_US  20
`define TDP_FLT_CYCLES   (`TDP_FLT_TIME_US * `TDP_CLK_MHZ)
// ==========================================================
// Counter and word widths, result FIFO depth
`define TDP_WD_W         18
`define TDP_FLT_W        13
`define TDP_RES_W        8
`define TDP_FIFO_DEPTH   4
`endif

// [tdp_pkg.sv]
// Types shared by the tone detector port control
package tdp_pkg;
    `include "tdp_map.svh"
    // ==========================================================
    // Port roles and serializer states
    typedef enum logic [1:0] {PR_DTMF, PR_GEN, PR_LOOP} tdp_role_e;
    typedef enum logic {SER_IDLE, SER_SHIFT} tdp_ser_e;
    // ==========================================================
    // Result word written by a touch-tone DSP
    typedef struct packed {
        logic [2:0] port;   // Source port number
        logic [4:0] code;   // Detected digit code
    } tdp_res_s;
    // ==========================================================
    // State of the control block, result FIFO not included
    typedef struct packed {
        logic                                   frm_s1;  // Frame sync stage 1
        logic                                   frm_s2;  // Frame sync stage 2
        logic                                   sck_s1;  // Result clock stage 1
        logic                                   sck_s2;  // Result clock stage 2
        logic                                   sck_d;   // Edge detect copy
        logic [`TDP_WD_W-1:0]                   wd_cnt;  // Processor watchdog
        logic                                   up_ok;   // Processor judged healthy
        logic [`TDP_NUM_DSP-1:0]                run;     // DSP in service
        logic [`TDP_NUM_DSP-1:0]                sn_s1;   // Health sync stage 1
        logic [`TDP_NUM_DSP-1:0]                sn_s2;   // Health sync stage 2
        logic [`TDP_NUM_DTMF-1:0]               tv_s1;   // Tone valid stage 1
        logic [`TDP_NUM_DTMF-1:0]               tv_s2;   // Tone valid stage 2
        logic [`TDP_NUM_DTMF-1:0][`TDP_FLT_W-1:0] flt;   // Filter counters
        logic [`TDP_NUM_DTMF-1:0]               tone_ok; // Recognised tone
        tdp_ser_e                               ser_st;  // Serializer state
        logic [`TDP_RES_W-1:0]                  shreg;   // Shift register
        logic [2:0]                             bitcnt;  // Bits left
        logic                                   sdo;     // Serial result bit
    } tdp_state_s;
endpackage : tdp_pkg

// [tdp_port_ctrl.sv]
// Port arrangement, DSP supervision and result path of the tone detector board
// Contract
// - eight ports, six with serializer elements
// - ports 0,1,4,5 are touch-tone detectors
// - ports 2 and 6 detect general tones
// - ports 3 and 7 loop back elements
// - each attached port: DSP, interface, restart; filter only on the touch-tone ports
// - frame signal synchronised before each DSP
// - processor failure removes all DSPs at once
// - DSPs restarted singly on command
// - sanity logic reports each DSP health
// - touch-tone results written synchronous to serial clock
// - filter recognises tones, blocks end-to-end signaling
`timescale 1ns/1ps
`include "tdp_map.svh"
// ==========================================================
// Result FIFO
module tdp_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0]  mem_ff [D];     // Word storage
    logic [AW-1:0] wr_ff;          // Write pointer
    logic [AW-1:0] rd_ff;          // Read pointer
    logic [AW:0]   cnt_ff;         // Words held
    logic          push;
    logic          pop;

    // Honest flags straight from the count
    assign in_ready  = (cnt_ff != (AW+1)'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and storage update
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_ff[wr_ff] <= in_data;
                wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop)
                rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : tdp_fifo

// ==========================================================
// Top level
module tdp_port_ctrl #(
    parameter int WD_CYCLES  = `TDP_WD_CYCLES,
    parameter int FLT_CYCLES = `TDP_FLT_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [5:0]              lnk_sclk,
    input  wire logic [5:0]              lnk_sdata,
    output logic [5:0]                   dsp_sclk,
    output logic [5:0]                   dsp_sdata,
    input  wire logic [1:0]              lb_tx,
    output logic [1:0]                   lb_rx,
    input  wire logic                    sys_frame,
    output logic [5:0]                   dsp_frame,
    input  wire logic                    up_kick,
    output logic                         up_ok,
    input  wire logic                    restart_cmd,
    input  wire logic [2:0]              restart_port,
    output logic [5:0]                   dsp_reset_n,
    input  wire logic [5:0]              dsp_sane,
    output logic [5:0]                   sane_stat,
    input  wire logic [3:0]              tone_valid,
    input  wire logic [3:0]              e2e_mode,
    output logic [3:0]                   tone_irq,
    input  wire logic                    res_en,
    input  wire logic                    res_valid,
    output logic                         res_ready,
    input  wire tdp_pkg::tdp_res_s       res_data,
    input  wire logic                    res_sclk,
    output logic                         res_sdata
);
    import tdp_pkg::*;

    // ==========================================================
    // Port map helpers
    // Role of a port number
    function automatic tdp_role_e port_role(input logic [2:0] p);
        case (p)
            3'h0, 3'h1, 3'h4, 3'h5: port_role = PR_DTMF;
            3'h2, 3'h6:             port_role = PR_GEN;
            default:                port_role = PR_LOOP;
        endcase
    endfunction : port_role

    // DSP slot of a port; loop ports own none
    function automatic logic [2:0] port_dsp(input logic [2:0] p);
        case (p)
            3'h0, 3'h1, 3'h2: port_dsp = p;
            3'h4, 3'h5, 3'h6: port_dsp = p - 3'h1;
            default:          port_dsp = `TDP_NO_DSP;
        endcase
    endfunction : port_dsp

    // DSP slots of the touch-tone ports 0, 1, 4, 5
    localparam logic [3:0][2:0] DTMF_DSP = {3'h4, 3'h3, 3'h1, 3'h0};

    tdp_state_s          cur_ff;     // Registered state
    tdp_state_s          nxt_cur;    // Next state
    logic                res_take;   // Result word accepted
    logic                fifo_ready; // FIFO has room
    logic                fo_valid;   // FIFO word waiting
    logic                fo_pop;     // Serializer takes word
    tdp_res_s            fo_data;    // Word at FIFO head
    logic                sck_rise;   // Result clock edge
    logic [2:0]          rs_dsp;     // Result source slot

    // ==========================================================
    // Direct paths
    // No logic in the serial lines keeps element timing intact
    assign dsp_sclk  = lnk_sclk;
    assign dsp_sdata = lnk_sdata;
    // Loop ports echo what the element sent
    assign lb_rx     = lb_tx;
    // One synchronised frame fans out to every DSP
    assign dsp_frame = {6{cur_ff.frm_s2}};
    assign up_ok       = cur_ff.up_ok;
    assign dsp_reset_n = cur_ff.run;
    // Health seen by the processor, only for DSPs in service
    assign sane_stat   = cur_ff.sn_s2 & cur_ff.run;
    assign res_sdata   = cur_ff.sdo;

    // ==========================================================
    // Result intake: only running touch-tone ports while enabled
    assign rs_dsp    = port_dsp(res_data.port);
    assign res_ready = fifo_ready && res_en && (port_role(res_data.port) == PR_DTMF)
                       && (rs_dsp != `TDP_NO_DSP) && cur_ff.run[rs_dsp];
    assign res_take  = res_valid && res_ready;
    assign sck_rise  = cur_ff.sck_s2 && !cur_ff.sck_d;
    assign fo_pop    = fo_valid && (cur_ff.ser_st == SER_IDLE) && sck_rise;

    // Buffer decouples processor writes from the slow serial clock
    tdp_fifo #(.W(`TDP_RES_W), .D(`TDP_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (res_take),
        .in_ready  (fifo_ready),
        .in_data   (res_data),
        .out_valid (fo_valid),
        .out_ready (fo_pop),
        .out_data  (fo_data)
    );

    // ==========================================================
    // Interrupt filter outputs, blocked in end-to-end mode
    generate
        for (genvar k = 0; k < `TDP_NUM_DTMF; k++)
        begin : g_irq
            assign tone_irq[k] = cur_ff.tone_ok[k] && !e2e_mode[k];
        end
    endgenerate

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        logic [2:0] sel;
        sel = port_dsp(restart_port);
        nxt_cur = cur_ff;
        // Two-stage capture of the frame, result clock, health and tone valid inputs
        nxt_cur.frm_s1 = sys_frame;
        nxt_cur.frm_s2 = cur_ff.frm_s1;
        nxt_cur.sck_s1 = res_sclk;
        nxt_cur.sck_s2 = cur_ff.sck_s1;
        nxt_cur.sck_d  = cur_ff.sck_s2;
        nxt_cur.sn_s1  = dsp_sane;
        nxt_cur.sn_s2  = cur_ff.sn_s1;
        nxt_cur.tv_s1  = tone_valid;
        nxt_cur.tv_s2  = cur_ff.tv_s1;
        // Processor watchdog: a kick restarts the count
        if (up_kick)
        begin
            nxt_cur.wd_cnt = '0;
            nxt_cur.up_ok  = 1'b1;
        end
        else if (cur_ff.wd_cnt >= `TDP_WD_W'(WD_CYCLES - 1))
            nxt_cur.up_ok  = 1'b0;
        else
            nxt_cur.wd_cnt = cur_ff.wd_cnt + 1'b1;
        // Restart control
        if (!cur_ff.up_ok)
            nxt_cur.run = '0;
        else if (restart_cmd && sel != `TDP_NO_DSP)
            nxt_cur.run[sel] = 1'b1;
        // Tone must hold steady for the filter time
        for (int k = 0; k < `TDP_NUM_DTMF; k++)
        begin
            if (!cur_ff.tv_s2[k] || !cur_ff.run[DTMF_DSP[k]])
            begin
                nxt_cur.flt[k]     = '0;
                nxt_cur.tone_ok[k] = 1'b0;
            end
            else if (cur_ff.flt[k] >= `TDP_FLT_W'(FLT_CYCLES - 1))
                nxt_cur.tone_ok[k] = 1'b1;
            else
                nxt_cur.flt[k] = cur_ff.flt[k] + 1'b1;
        end
        // Serializer: one bit per rising result clock, msb first
        case (cur_ff.ser_st)
            SER_IDLE:
            begin
                if (fo_pop)
                begin
                    nxt_cur.shreg  = {fo_data[`TDP_RES_W-2:0], 1'b0};
                    nxt_cur.sdo    = fo_data[`TDP_RES_W-1];
                    nxt_cur.bitcnt = 3'h7;
                    nxt_cur.ser_st = SER_SHIFT;
                end
            end
            SER_SHIFT:
            begin
                if (sck_rise)
                begin
                    nxt_cur.sdo    = cur_ff.shreg[`TDP_RES_W-1];
                    nxt_cur.shreg  = {cur_ff.shreg[`TDP_RES_W-2:0], 1'b0};
                    nxt_cur.bitcnt = cur_ff.bitcnt - 1'b1;
                    if (cur_ff.bitcnt == 3'h1)
                        nxt_cur.ser_st = SER_IDLE;
                end
            end
            default: nxt_cur.ser_st = SER_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end

    // ==========================================================
    // Checks
    sequence s_up_down;
        !cur_ff.up_ok;
    endsequence
    chk_all_out_down: assert property (@(posedge clk) disable iff (rst)
        s_up_down |=> (cur_ff.run == '0))
        else $error("DSP left running after processor fault");
    chk_single_restart: assert property (@(posedge clk) disable iff (rst)
        ($countones(cur_ff.run & ~$past(cur_ff.run)) <= 1))
        else $error("More than one DSP restarted at once");
    chk_loop_no_dsp: assert property (@(posedge clk) disable iff (rst)
        (cur_ff.up_ok && restart_cmd && restart_port[1:0] == 2'h3) |=> $stable(cur_ff.run))
        else $error("Loop port restart changed a DSP");
    chk_frame_sync: assert property (@(posedge clk) disable iff (rst)
        ##2 (dsp_frame[0] == $past(sys_frame, 2)))
        else $error("Frame not two stages behind pin");
    chk_irq_block: assert property (@(posedge clk) disable iff (rst)
        e2e_mode[0] |-> !tone_irq[0])
        else $error("Tone interrupt passed in end-to-end mode");
    chk_filter_hold: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_ff.tone_ok[1]) |-> ($past(cur_ff.flt[1]) == `TDP_FLT_W'(FLT_CYCLES - 1)))
        else $error("Tone recognised without steady input");
    chk_res_dtmf: assert property (@(posedge clk) disable iff (rst)
        res_take |-> (port_role(res_data.port) == PR_DTMF) && res_en)
        else $error("Result accepted from a non touch-tone port");
    chk_sane_gate: assert property (@(posedge clk) disable iff (rst)
        sane_stat[2] == (cur_ff.run[2] && $past(dsp_sane[2], 2)))
        else $error("Health status does not follow DSP slot 2");
    chk_ser_edge: assert property (@(posedge clk) disable iff (rst)
        (cur_ff.ser_st == SER_SHIFT && !sck_rise) |=> $stable(cur_ff.sdo))
        else $error("Result bit moved without clock edge");
endmodule : tdp_port_ctrl

// [tdp_far_model.sv]
// Far side model: serializer element link lines and result clock receiver
`timescale 1ns/1ps
// ==========================================================
// Element and result receiver model
module tdp_far_model (
    output logic [5:0] lnk_sclk,  // Element serial clocks
    output logic [5:0] lnk_sdata, // Element serial data
    output logic       res_sclk,  // Result shift clock
    input  wire logic  res_sdata  // Result bits from the block
);
    logic [7:0] got_q[$];     // Words gathered, msb first
    logic [7:0] sh;           // Bits gathered so far
    int         seed = 56086; // Fixed seed for link data
    initial
    begin
        lnk_sclk  = 6'h00;
        lnk_sdata = 6'h00;
        res_sclk  = 1'b0;
    end
    // One frame of link traffic; clock stands still afterwards
    task automatic link_burst(input int n);
        #1.3;
        for (int i = 0; i < n; i++)
        begin
            lnk_sdata = 6'($random(seed));
            #24 lnk_sclk = 6'h3f;
            #24 lnk_sclk = 6'h00;
        end
        // Released data shows the inverse, never the last value
        lnk_sdata = ~lnk_sdata;
    endtask : link_burst
    // Result clock for n bits; each bit taken just before the next rise
    task automatic clock_bits(input int n);
        #1.3;
        for (int i = 0; i < n; i++)
        begin
            res_sclk = 1'b1;
            #24 res_sclk = 1'b0;
            #23 sh = {sh[6:0], res_sdata};
            #1;
            if (i % 8 == 7)
                got_q.push_back(sh);
        end
    endtask : clock_bits
endmodule : tdp_far_model

// [tb_tone_detector_port_control.sv]
// Self-checking bench for the tone detector port control
`timescale 1ns/1ps
// ==========================================================
// Bench top
module tb_tone_detector_port_control;
    import tdp_pkg::*;
    localparam int WD  = 50; // Shortened watchdog
    localparam int FLT = 8;  // Shortened filter count
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [5:0] lnk_sclk, lnk_sdata, dsp_sclk, dsp_sdata, dsp_frame, dsp_reset_n;
    logic [5:0] dsp_sane, sane_stat;
    logic [1:0] lb_tx, lb_rx;
    logic [3:0] tone_valid, e2e_mode, tone_irq;
    logic [2:0] restart_port;
    logic       sys_frame, up_kick = 1'b0, up_ok, restart_cmd, res_en, res_valid, res_ready;
    logic       res_sclk, res_sdata, kick_on;
    tdp_res_s   res_data;
    int         err_count, n_checks, kc, i;
    int         seed = 56086;  // Fixed seed for bench stimulus
    logic [5:0] exp_run;       // Model of DSPs in service
    logic [7:0] exp_q[$];      // Model of words sent out
    tdp_port_ctrl #(.WD_CYCLES(WD), .FLT_CYCLES(FLT)) dut_u (.clk(clk), .rst(rst),
        .lnk_sclk(lnk_sclk), .lnk_sdata(lnk_sdata), .dsp_sclk(dsp_sclk), .dsp_sdata(dsp_sdata),
        .lb_tx(lb_tx), .lb_rx(lb_rx), .sys_frame(sys_frame), .dsp_frame(dsp_frame),
        .up_kick(up_kick), .up_ok(up_ok), .restart_cmd(restart_cmd),
        .restart_port(restart_port), .dsp_reset_n(dsp_reset_n), .dsp_sane(dsp_sane),
        .sane_stat(sane_stat), .tone_valid(tone_valid), .e2e_mode(e2e_mode),
        .tone_irq(tone_irq), .res_en(res_en), .res_valid(res_valid), .res_ready(res_ready),
        .res_data(res_data), .res_sclk(res_sclk), .res_sdata(res_sdata));
    tdp_far_model far_u (.lnk_sclk(lnk_sclk), .lnk_sdata(lnk_sdata), .res_sclk(res_sclk),
        .res_sdata(res_sdata));
    // ==========================================================
    // Clock and processor heartbeat, one pulse every ten cycles
    always #2.5 clk = ~clk;
    always @(negedge clk)
    begin
        kc      <= kc + 1;
        up_kick <= kick_on && (kc % 10 == 0);
    end
    // ==========================================================
    // Helpers
    task automatic give_verdict;
        $display("checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : check
    // DSP slot of a port; loop-back ports have none
    function automatic int slot(input int p);
        return (p == 3 || p == 7) ? -1 : ((p > 3) ? p - 1 : p);
    endfunction : slot
    // Restart pulse for one port, answer looked at two cycles on
    task automatic restart(input int p);
        restart_cmd  = 1'b1;
        restart_port = p[2:0];
        @(negedge clk) restart_cmd = 1'b0;
        @(negedge clk);
    endtask : restart
    // Bounded wait on a level; running out ends the run
    task automatic wait_lvl(input string what, ref logic sig, input logic want);
        for (i = 0; i < 200 && sig !== want; i++)
            @(negedge clk);
        if (sig !== want)
        begin
            check(what, want, sig);
            give_verdict();
        end
    endtask : wait_lvl
    // Offer one word and hold it until taken; valid stays up for the next
    task automatic push(input logic [2:0] p);
        res_data.port = p;
        res_data.code = 5'($random(seed));
        res_valid     = 1'b1;
        #1 wait_lvl("res_ready wait", res_ready, 1'b1);
        exp_q.push_back(res_data);
        @(negedge clk);
    endtask : push
    // ==========================================================
    // Main sequence
    initial
    begin
        {lb_tx, sys_frame, restart_cmd, restart_port, dsp_sane, tone_valid} = '0;
        {e2e_mode, res_en, res_valid, res_data, kick_on} = '0;
        {err_count, n_checks, exp_run} = '0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        check("dsp_reset_n", 6'h00, dsp_reset_n);
        check("up_ok", 1'b0, up_ok);
        check("res_ready", 1'b0, res_ready);
        // Link lines and loop-back are plain wires
        fork
            far_u.link_burst(30);
            repeat (300)
            begin
                @(negedge clk) lb_tx = 2'($random(seed));
                #1 check("dsp_sclk", lnk_sclk, dsp_sclk);
                check("dsp_sdata", lnk_sdata, dsp_sdata);
                check("lb_rx", lb_tx, lb_rx);
            end
        join
        restart(0);
        check("dsp_reset_n refused", 6'h00, dsp_reset_n);
        kick_on = 1'b1;
        wait_lvl("up_ok wait", up_ok, 1'b1);
        // Each port restarted singly; health reported per running DSP
        for (int p = 0; p < 8; p++)
        begin
            restart(p);
            if (slot(p) >= 0)
                exp_run[slot(p)] = 1'b1;
            check("dsp_reset_n", exp_run, dsp_reset_n);
            dsp_sane = 6'($random(seed));
            repeat (3) @(negedge clk);
            check("sane_stat", dsp_sane & exp_run, sane_stat);
        end
        // Frame signal reaches every DSP only after synchronising
        for (int f = 0; f < 4; f++)
        begin
            sys_frame = ~sys_frame;
            @(negedge clk) check("dsp_frame early", {6{~sys_frame}}, dsp_frame);
            repeat (2) @(negedge clk);
            check("dsp_frame", {6{sys_frame}}, dsp_frame);
        end
        // Tone filter: short tone refused, long tone passed unless end-to-end
        for (int k = 0; k < 4; k++)
        begin
            e2e_mode      = 4'($random(seed));
            tone_valid[k] = 1'b1;
            repeat (FLT - 2) @(negedge clk);
            check("tone_irq short", 4'h0, tone_irq);
            tone_valid[k] = 1'b0;
            @(negedge clk) tone_valid[k] = 1'b1;
            repeat (FLT + 6) @(negedge clk);
            check("tone_irq", ~e2e_mode & (4'h1 << k), tone_irq);
            e2e_mode = ~e2e_mode;
            #1 check("tone_irq e2e", ~e2e_mode & (4'h1 << k), tone_irq);
            tone_valid[k] = 1'b0;
            repeat (4) @(negedge clk);
            check("tone_irq off", 4'h0, tone_irq);
        end
        // Results: general tone port refused, FIFO filled then drained
        res_en        = 1'b1;
        res_data.port = 3'h2;
        res_valid     = 1'b1;
        #1 check("res_ready general port", 1'b0, res_ready);
        foreach (exp_run[j])
            if (j < 4)
                push((j < 2) ? j[2:0] : j[2:0] + 3'h2);
        res_data.port = 3'h0;
        repeat (3) @(negedge clk);
        check("res_ready full", 1'b0, res_ready);
        res_valid = 1'b0;
        far_u.clock_bits(32);
        for (int w = 0; w < 4; w++)
            check("serial word", exp_q[w], far_u.got_q[w]);
        // Heartbeat stops: every DSP out of service together
        kick_on = 1'b0;
        wait_lvl("up_ok fall", up_ok, 1'b0);
        @(negedge clk) check("dsp_reset_n drop", 6'h00, dsp_reset_n);
        restart(1);
        check("dsp_reset_n refused", 6'h00, dsp_reset_n);
        give_verdict();
    end
endmodule : tb_tone_detector_port_control
